// ===== include/bct_defines.vh
// Functional notes
// - after a local transfer drive bus busy inactive on rise, release on next fall
// - single-sample variant: ack alone normal, error means bus error, halt alone retry
// - burst variant: ack alone normal, error alone bus error, both means retry
// - single-sample variant samples termination inputs on local clock rising edge
// - disconnect keeps target ready and stop both active
// - bursts to an i/o mapped image disconnect after first data phase
// - non-posted burst write disconnects once its delayed write completes locally
// - burst read disconnects once the single fetched local transfer completes
// - burst disconnects when the address reaches a 128-byte boundary
// - disconnect when posted-write fifo fills or burst needs non-linear incrementing
// - optional disconnect after eight clocks without target ready; restart prefetch
// - retry drives stop active with target ready inactive, no data moved
// - posted write retried when fifo free entries fall below cacheline setting
// - retry any access while a delayed transaction is in progress
// - retry burst read until its local read has terminated
// - retry writes while any read in either channel is incomplete
// - abort drives stop active with devsel inactive, ending cleanly
// - delayed cycles retried until local normal or error; then complete or abort
// - posted writes complete on pci regardless of local outcome
// - logging on: capture address, code, data, size of failed write, set flag
// - while flag set freeze posted fifo and suspend target channel
// - logging off: drop failed posted write and continue without stalling
// - log interrupt only when enabled; direction bit picks local or pci
`ifndef BCT_DEFINES_VH
`define BCT_DEFINES_VH
`define BCT_FIFO_W        32
`define BCT_FIFO_D        16
`define BCT_FIFO_AW       4
`define BCT_BOUNDARY_BIT  7
`define BCT_PD_WAIT       4'h8
`define BCT_CL_FOUR       5'h04
`define BCT_CL_EIGHT      5'h08
`define BCT_TERM_NONE     2'h0
`define BCT_TERM_NORMAL   2'h1
`define BCT_TERM_BERR     2'h2
`define BCT_TERM_RETRY    2'h3
`endif

// ===== rtl/bct_fifo.v
`timescale 1ns/100ps
module bct_fifo #(
    parameter W  = 32,
    parameter D  = 16,
    parameter AW = 4
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          ce,
    input  wire [W-1:0]  in_data,
    input  wire          in_valid,
    output wire          in_ready,
    output wire [W-1:0]  out_data,
    output wire          out_valid,
    input  wire          out_ready,
    input  wire          drop,
    output wire [AW:0]   level
);
    reg [W-1:0] mem [0:D-1];
    reg [AW:0]  wp;
    reg [AW:0]  rp;
    wire        full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    wire        empty = (wp == rp);
    wire        push  = in_valid && !full;
    wire        pop   = (out_ready || drop) && !empty;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rp[AW-1:0]];
    assign level     = wp - rp;
    always @(posedge clk)
    begin
        if (ce && push)
            mem[wp[AW-1:0]] <= in_data;
    end
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp <= {(AW+1){1'b0}};
            rp <= {(AW+1){1'b0}};
        end
        else if (ce)
        begin
            if (push)
                wp <= wp + 1'b1;
            if (pop)
                rp <= rp + 1'b1;
        end
    end
endmodule

// ===== rtl/bct_top.v
`timescale 1ns/100ps
`include "bct_defines.vh"
module bct_top (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ce,
    // pci target side, pci signals active high here
    input  wire        pci_req,
    input  wire        pci_write,
    input  wire        pci_burst,
    input  wire        pci_io_image,
    input  wire        pci_posted_en,
    input  wire        pci_prefetch,
    input  wire        pci_nonlinear,
    input  wire [31:0] pci_addr,
    input  wire [31:0] pci_wdata,
    input  wire [3:0]  pci_tcode,
    input  wire [1:0]  pci_size,
    input  wire        pci_data_phase,
    input  wire        pci_trdy_wait,
    input  wire        read_pending_other,
    input  wire        prefetch_disconnect_enable,
    input  wire        cacheline_size_setting,
    input  wire        burst_variant,
    input  wire        error_log_enable,
    input  wire        error_log_irq_enable,
    input  wire        error_log_irq_direction,
    input  wire        error_flag_clear,
    // local bus, termination and bus busy pins active low
    input  wire        local_bus_clock,
    input  wire        transfer_acknowledge_n,
    input  wire        transfer_error_ack_n,
    input  wire        halt_or_retry_n,
    input  wire        local_done_cycle,
    output reg         bus_busy_grant_ack_o,
    output reg         bus_busy_grant_ack_oe,
    output reg         local_req,
    output reg         local_posted,
    output reg  [31:0] local_addr,
    output reg  [31:0] local_wdata,
    output reg         pci_stop,
    output reg         pci_trdy,
    output reg         pci_devsel,
    output reg         prefetch_restart,
    output reg         error_logged_flag,
    output reg  [31:0] local_error_address,
    output reg  [31:0] local_error_data,
    output reg  [3:0]  local_error_code,
    output reg  [1:0]  local_error_size,
    output reg         irq_local,
    output reg         irq_pci
);
    localparam S_IDLE = 4'h1;
    localparam S_WAIT = 4'h2;
    localparam S_REL  = 4'h4;
    localparam S_OFF  = 4'h8;

    // two-flop synchronisers for the local clock and termination pins
    reg [3:0] s1;
    reg [3:0] s2;
    reg       lclk_d;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // clock bit idles low like lclk_d, so no false local edge follows reset
            s1     <= 4'h7;
            s2     <= 4'h7;
            lclk_d <= 1'b0;
        end
        else if (ce)
        begin
            s1     <= {local_bus_clock, transfer_acknowledge_n,
                       transfer_error_ack_n, halt_or_retry_n};
            s2     <= s1;
            lclk_d <= s2[3];
        end
    end
    wire lrise = s2[3] && !lclk_d;
    wire lfall = !s2[3] && lclk_d;
    wire ta    = !s2[2];
    wire tea   = !s2[1];
    wire hr    = !s2[0];

    function [1:0] decode_term;
        input v;
        input a;
        input e;
        input h;
        begin
            if (v)
            begin
                if (a && e)
                    decode_term = `BCT_TERM_RETRY;
                else if (e)
                    decode_term = `BCT_TERM_BERR;
                else if (a)
                    decode_term = `BCT_TERM_NORMAL;
                else
                    decode_term = `BCT_TERM_NONE;
            end
            else
            begin
                if (e)
                    decode_term = `BCT_TERM_BERR;
                else if (a)
                    decode_term = `BCT_TERM_NORMAL;
                else if (h)
                    decode_term = `BCT_TERM_RETRY;
                else
                    decode_term = `BCT_TERM_NONE;
            end
        end
    endfunction
    wire [1:0] term = decode_term(burst_variant, ta, tea, hr);

    // posted write queue
    wire        pw_in_ready;
    wire [31:0] pw_out_data;
    wire        pw_out_valid;
    wire [4:0]  pw_level;
    reg         pw_pop;
    reg         pw_drop;
    wire [4:0]  pw_free = 5'h10 - pw_level;
    wire [4:0]  cl_need = cacheline_size_setting ? `BCT_CL_EIGHT : `BCT_CL_FOUR;
    wire        posting = pci_write && pci_posted_en && !pci_io_image;
    wire        retry_cond;
    // a retried write must not leave its data behind in the queue
    wire        pw_push = pci_req && pci_data_phase && posting && pw_in_ready
                          && !error_logged_flag && !retry_cond;
    bct_fifo #(
        .W  (`BCT_FIFO_W),
        .D  (`BCT_FIFO_D),
        .AW (`BCT_FIFO_AW)
    ) u_pw (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_data   (pci_wdata),
        .in_valid  (pw_push),
        .in_ready  (pw_in_ready),
        .out_data  (pw_out_data),
        .out_valid (pw_out_valid),
        .out_ready (pw_pop),
        .drop      (pw_drop),
        .level     (pw_level)
    );

    // local master and delayed transaction tracking
    reg [3:0]  st;
    reg        delayed_busy;
    reg        delayed_read;
    reg [1:0]  delayed_result;
    reg        cur_posted;
    reg [3:0]  cur_code;
    reg [1:0]  cur_size;
    reg [3:0]  wait_cnt;
    wire       new_delayed = pci_req && !posting && !delayed_busy && !retry_cond
                             && delayed_result == `BCT_TERM_NONE;
    wire       result_hit  = pci_req && !delayed_busy
                             && delayed_result != `BCT_TERM_NONE;

    assign retry_cond = pci_req && (
        delayed_busy
        || (pci_write && read_pending_other)
        || (posting && !pci_data_phase && pw_free < cl_need)
        || error_logged_flag);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st                    <= S_IDLE;
            bus_busy_grant_ack_o  <= 1'b1;
            bus_busy_grant_ack_oe <= 1'b0;
            local_req             <= 1'b0;
            local_posted          <= 1'b0;
            local_addr            <= 32'h00000000;
            local_wdata           <= 32'h00000000;
            delayed_busy          <= 1'b0;
            delayed_read          <= 1'b0;
            delayed_result        <= `BCT_TERM_NONE;
            cur_posted            <= 1'b0;
            cur_code              <= 4'h0;
            cur_size              <= 2'h0;
            pw_pop                <= 1'b0;
            pw_drop               <= 1'b0;
            error_logged_flag     <= 1'b0;
            local_error_address   <= 32'h00000000;
            local_error_data      <= 32'h00000000;
            local_error_code      <= 4'h0;
            local_error_size      <= 2'h0;
        end
        else if (ce)
        begin
            pw_pop  <= 1'b0;
            pw_drop <= 1'b0;
            if (result_hit)
                delayed_result <= `BCT_TERM_NONE;
            // set wins over software clear
            if (error_flag_clear)
                error_logged_flag <= 1'b0;
            case (st)
                S_IDLE:
                begin
                    if (new_delayed)
                    begin
                        st                    <= S_WAIT;
                        delayed_busy          <= 1'b1;
                        delayed_read          <= !pci_write;
                        cur_posted            <= 1'b0;
                        local_posted          <= 1'b0;
                        local_addr            <= pci_addr;
                        local_wdata           <= pci_wdata;
                        local_req             <= 1'b1;
                        bus_busy_grant_ack_o  <= 1'b0;
                        bus_busy_grant_ack_oe <= 1'b1;
                    end
                    else if (pw_out_valid && !error_logged_flag)
                    begin
                        st                    <= S_WAIT;
                        cur_posted            <= 1'b1;
                        local_posted          <= 1'b1;
                        local_addr            <= pci_addr;
                        local_wdata           <= pw_out_data;
                        cur_code              <= pci_tcode;
                        cur_size              <= pci_size;
                        local_req             <= 1'b1;
                        bus_busy_grant_ack_o  <= 1'b0;
                        bus_busy_grant_ack_oe <= 1'b1;
                    end
                end
                S_WAIT:
                begin
                    if (lrise && term != `BCT_TERM_NONE)
                    begin
                        local_req <= 1'b0;
                        if (term == `BCT_TERM_RETRY)
                            local_req <= 1'b1;
                        else
                        begin
                            st                   <= S_REL;
                            bus_busy_grant_ack_o <= 1'b1;
                            if (cur_posted)
                            begin
                                if (term == `BCT_TERM_BERR && error_log_enable)
                                begin
                                    error_logged_flag   <= 1'b1;
                                    local_error_address <= local_addr;
                                    local_error_data    <= local_wdata;
                                    local_error_code    <= cur_code;
                                    local_error_size    <= cur_size;
                                    pw_drop             <= 1'b1;
                                end
                                else
                                    pw_pop <= 1'b1;
                            end
                            else
                            begin
                                delayed_busy   <= 1'b0;
                                delayed_result <= term;
                            end
                        end
                    end
                end
                S_REL:
                begin
                    if (lfall)
                    begin
                        st                    <= S_OFF;
                        bus_busy_grant_ack_oe <= 1'b0;
                    end
                end
                S_OFF:
                    st <= S_IDLE;
                default:
                    st <= S_IDLE;
            endcase
        end
    end

    // pci target terminations
    wire at_boundary = &pci_addr[`BCT_BOUNDARY_BIT-1:2];
    wire disc = pci_burst && (pci_io_image
                || (pci_write && !posting)
                || !pci_write
                || at_boundary
                || (posting && pw_level >= 5'h0F)
                || pci_nonlinear);
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pci_stop         <= 1'b0;
            pci_trdy         <= 1'b0;
            pci_devsel       <= 1'b0;
            wait_cnt         <= 4'h0;
            prefetch_restart <= 1'b0;
            irq_local        <= 1'b0;
            irq_pci          <= 1'b0;
        end
        else if (ce)
        begin
            pci_stop         <= 1'b0;
            pci_trdy         <= 1'b0;
            pci_devsel       <= 1'b0;
            prefetch_restart <= 1'b0;
            irq_local <= error_logged_flag && error_log_irq_enable
                         && !error_log_irq_direction;
            irq_pci   <= error_logged_flag && error_log_irq_enable
                         && error_log_irq_direction;
            if (pci_req && pci_prefetch && pci_trdy_wait)
                wait_cnt <= (wait_cnt == `BCT_PD_WAIT) ? wait_cnt : wait_cnt + 4'h1;
            else
                wait_cnt <= 4'h0;
            if (pci_req && prefetch_disconnect_enable && pci_prefetch
                && wait_cnt == `BCT_PD_WAIT - 4'h1 && pci_trdy_wait && !error_logged_flag)
            begin
                pci_stop         <= 1'b1;
                pci_trdy         <= 1'b1;
                pci_devsel       <= 1'b1;
                prefetch_restart <= 1'b1;
            end
            else if (result_hit && delayed_result == `BCT_TERM_BERR)
                pci_stop <= 1'b1;
            else if (retry_cond)
            begin
                pci_stop   <= 1'b1;
                pci_devsel <= 1'b1;
            end
            else if (result_hit || (posting && pci_req))
            begin
                pci_trdy   <= 1'b1;
                pci_devsel <= 1'b1;
                pci_stop   <= disc;
            end
            else if (new_delayed)
            begin
                pci_stop   <= 1'b1;
                pci_devsel <= 1'b1;
            end
        end
    end
endmodule

// ===== verif/bct_checker_sva.sv
`timescale 1ns/100ps
module bct_checker (
    input wire clk,
    input wire rst_n,
    input wire pci_stop,
    input wire pci_trdy,
    input wire pci_devsel,
    input wire bus_busy_grant_ack_o,
    input wire bus_busy_grant_ack_oe,
    input wire error_logged_flag,
    input wire error_log_enable,
    input wire error_log_irq_enable,
    input wire error_log_irq_direction,
    input wire irq_local,
    input wire irq_pci
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_trdy_devsel; pci_trdy |-> pci_devsel; endproperty
    a_trdy_devsel: assert property (p_trdy_devsel)
        else $error("target ready without device select");
    property p_abort_clean; pci_stop && !pci_devsel |-> !pci_trdy; endproperty
    a_abort_clean: assert property (p_abort_clean)
        else $error("abort moved data");
    property p_release_high;
        $fell(bus_busy_grant_ack_oe) |-> bus_busy_grant_ack_o && $past(bus_busy_grant_ack_o);
    endproperty
    a_release_high: assert property (p_release_high)
        else $error("bus busy released while still driven active");
    // the release waits for a synchronised local falling edge, so allow 12 clocks, three local half cycles
    property p_release_soon;
        $rose(bus_busy_grant_ack_o) && bus_busy_grant_ack_oe |-> ##[1:12] !bus_busy_grant_ack_oe;
    endproperty
    a_release_soon: assert property (p_release_soon)
        else $error("bus busy not released after inactive drive");
    property p_irq_local;
        $rose(irq_local) |-> error_logged_flag && error_log_irq_enable && !error_log_irq_direction;
    endproperty
    a_irq_local: assert property (p_irq_local)
        else $error("local interrupt without enabled logged error");
    property p_irq_pci;
        $rose(irq_pci) |-> error_logged_flag && error_log_irq_enable && error_log_irq_direction;
    endproperty
    a_irq_pci: assert property (p_irq_pci)
        else $error("pci interrupt without enabled logged error");
    property p_log_enabled; $rose(error_logged_flag) |-> error_log_enable; endproperty
    a_log_enabled: assert property (p_log_enabled)
        else $error("error logged while logging off");
    property p_frozen; pci_trdy |-> !$past(error_logged_flag); endproperty
    a_frozen: assert property (p_frozen)
        else $error("target channel accepted data while error logged");
    c_abort: cover property (pci_stop && !pci_devsel);
    c_retry: cover property (pci_stop && pci_devsel && !pci_trdy);
    c_logged: cover property ($rose(error_logged_flag));
endmodule
bind bct_top bct_checker u_chk (.*);

// ===== verif/bct_local_model.sv
`timescale 1ns/100ps
`include "bct_defines.vh"
module bct_local_model (
    input  wire       local_req,
    input  wire       burst_variant,
    input  wire [1:0] term_sel,
    output reg        local_bus_clock,
    output reg        transfer_acknowledge_n,
    output reg        transfer_error_ack_n,
    output reg        halt_or_retry_n
);
    reg answered;
    reg retried;
    initial
    begin
        local_bus_clock = 1'h0;
        transfer_acknowledge_n = 1'h1;
        transfer_error_ack_n = 1'h1;
        halt_or_retry_n = 1'h1;
        answered = 1'h0;
        retried = 1'h0;
    end
    // the processor bus clock runs free, also between cycles
    always #400 local_bus_clock = ~local_bus_clock;
    // one termination per local cycle, then the lines fall back to the pull-up level
    // driven after the falling edge so the lines stand settled at the rising edge
    always @(negedge local_bus_clock)
    begin
        transfer_acknowledge_n <= 1'h1;
        transfer_error_ack_n <= 1'h1;
        halt_or_retry_n <= 1'h1;
        answered <= 1'h0;
        if (local_req && !answered)
        begin
            answered <= 1'h1;
            retried <= 1'h0;
            if (term_sel == `BCT_TERM_RETRY && !retried)
            begin
                retried <= 1'h1;
                transfer_acknowledge_n <= ~burst_variant;
                transfer_error_ack_n <= ~burst_variant;
                halt_or_retry_n <= burst_variant;
            end
            else if (term_sel == `BCT_TERM_BERR)
            begin
                // single-sample variant: ack also low, error must still win
                transfer_acknowledge_n <= burst_variant;
                transfer_error_ack_n <= 1'h0;
            end
            else
                transfer_acknowledge_n <= 1'h0;
        end
    end
endmodule

// ===== verif/bridge_cycle_termination_tb.sv
`timescale 1ns/100ps
`include "bct_defines.vh"
module bridge_cycle_termination_tb;
    reg         clk = 1'h0;
    reg         rst_n = 1'h0;
    reg         ce = 1'h1;
    reg         pci_req = 1'h0;
    reg         pci_write = 1'h0;
    reg         pci_burst = 1'h0;
    reg         pci_io_image = 1'h0;
    reg         pci_posted_en = 1'h0;
    reg         pci_prefetch = 1'h0;
    reg         pci_nonlinear = 1'h0;
    reg  [31:0] pci_addr = 32'h0;
    reg  [31:0] pci_wdata = 32'h0;
    reg  [3:0]  pci_tcode = 4'h6;
    reg  [1:0]  pci_size = 2'h2;
    reg         pci_data_phase = 1'h0;
    reg         pci_trdy_wait = 1'h0;
    reg         read_pending_other = 1'h0;
    reg         prefetch_disconnect_enable = 1'h0;
    reg         cacheline_size_setting = 1'h0;
    reg         burst_variant = 1'h0;
    reg         error_log_enable = 1'h0;
    reg         error_log_irq_enable = 1'h0;
    reg         error_log_irq_direction = 1'h0;
    reg         error_flag_clear = 1'h0;
    reg         local_done_cycle = 1'h0;
    reg  [1:0]  term_sel = 2'h1;
    reg  [2:0]  ans;
    wire        local_bus_clock, transfer_acknowledge_n, transfer_error_ack_n, halt_or_retry_n;
    wire        bus_busy_grant_ack_o, bus_busy_grant_ack_oe, local_req, local_posted;
    wire [31:0] local_addr, local_wdata, local_error_address, local_error_data;
    wire        pci_stop, pci_trdy, pci_devsel, prefetch_restart, error_logged_flag;
    wire [3:0]  local_error_code;
    wire [1:0]  local_error_size;
    wire        irq_local, irq_pci;
    integer     error_cnt = 0;
    integer     n_tests = 0;
    integer     v;
    integer     t;
    bct_top DUT (.*);
    bct_local_model u_far (.*);
    always #50 clk = ~clk;
    task print_verdict;
        begin
            $display("tests=%0d errors=%0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // one request cycle; answer is {stop, trdy, devsel}
    task pci_cyc(input w, input b, input [31:0] a, output [2:0] r);
        integer k;
        begin
            @(posedge clk);
            pci_req <= 1'h1;
            pci_write <= w;
            pci_burst <= b;
            pci_posted_en <= w;
            pci_prefetch <= ~w;
            pci_data_phase <= w;
            pci_addr <= a;
            pci_wdata <= a ^ 32'hFFFF_0000;
            @(posedge clk);
            pci_req <= 1'h0;
            pci_data_phase <= 1'h0;
            r = 3'h0;
            for (k = 0; k < 3 && r === 3'h0; k = k + 1)
            begin
                @(negedge clk);
                r = {pci_stop, pci_trdy, pci_devsel};
            end
        end
    endtask
    task wait_for(input integer sel);
        integer k;
        begin
            k = 0;
            while (k < 200 && (sel == 0 ? bus_busy_grant_ack_oe !== 1'h0
                                        : error_logged_flag !== 1'h1))
            begin
                @(negedge clk);
                k = k + 1;
            end
            if (k == 200)
            begin
                chk(32'hDEAD, sel);
                print_verdict;
            end
        end
    endtask
    // master repeats the delayed read until it is no longer retried
    task rd_loop(input [2:0] exp);
        integer k;
        begin
            pci_cyc(1'h0, 1'h1, 32'h0000_1000, ans);
            chk(ans, 3'h5);
            pci_cyc(1'h1, 1'h0, 32'h0000_1100, ans);
            chk(ans, 3'h5);
            k = 0;
            while (ans === 3'h5 && k < 60)
            begin
                repeat (4) @(posedge clk);
                pci_cyc(1'h0, 1'h1, 32'h0000_1000, ans);
                k = k + 1;
            end
            chk(ans, exp);
            if (k == 60)
                print_verdict;
            wait_for(0);
            chk(bus_busy_grant_ack_o, 1'h1);
        end
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        chk({bus_busy_grant_ack_o, bus_busy_grant_ack_oe, error_logged_flag, irq_local, irq_pci},
            5'h10);
        for (v = 0; v < 2; v = v + 1)
            for (t = 1; t < 4; t = t + 1)
            begin
                burst_variant <= v[0];
                term_sel <= t[1:0];
                rd_loop(t == `BCT_TERM_BERR ? 3'h4 : 3'h7);
            end
        read_pending_other <= 1'h1;
        pci_cyc(1'h1, 1'h0, 32'h0000_1200, ans);
        chk(ans, 3'h5);
        read_pending_other <= 1'h0;
        term_sel <= `BCT_TERM_BERR;
        error_log_enable <= 1'h1;
        error_log_irq_enable <= 1'h1;
        cacheline_size_setting <= 1'h1;
        for (v = 0; v < 2; v = v + 1)
        begin
            error_log_irq_direction <= v[0];
            pci_cyc(1'h1, 1'h0, 32'h0000_2040 + v * 4, ans);
            chk(ans, 3'h3);
            wait_for(1);
            chk(local_error_address, 32'h0000_2040 + v * 4);
            chk(local_error_data, (32'h0000_2040 + v * 4) ^ 32'hFFFF_0000);
            chk({local_error_size, local_error_code}, 6'h26);
            // the interrupt is registered one clock after the flag
            @(negedge clk);
            chk({irq_local, irq_pci}, v ? 2'h1 : 2'h2);
            pci_cyc(1'h1, 1'h0, 32'h0000_3000, ans);
            chk(ans, 3'h5);
            @(posedge clk);
            error_flag_clear <= 1'h1;
            @(posedge clk);
            error_flag_clear <= 1'h0;
            repeat (2) @(posedge clk);
            chk(error_logged_flag, 1'h0);
        end
        error_log_enable <= 1'h0;
        pci_cyc(1'h1, 1'h0, 32'h0000_2100, ans);
        chk(ans, 3'h3);
        repeat (40) @(posedge clk);
        chk(error_logged_flag, 1'h0);
        term_sel <= `BCT_TERM_NORMAL;
        pci_cyc(1'h1, 1'h0, 32'h0000_2104, ans);
        chk(ans, 3'h3);
        pci_cyc(1'h1, 1'h1, 32'h0000_2180, ans);
        chk(ans, 3'h3);
        pci_cyc(1'h1, 1'h1, 32'h0000_217C, ans);
        chk(ans, 3'h7);
        // read held with target ready idle: disconnect on the eighth clock
        @(posedge clk);
        prefetch_disconnect_enable <= 1'h1;
        pci_req <= 1'h1;
        pci_write <= 1'h0;
        pci_prefetch <= 1'h1;
        pci_trdy_wait <= 1'h1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({pci_stop, pci_trdy, pci_devsel, prefetch_restart}, 4'hF);
        @(posedge clk);
        pci_req <= 1'h0;
        pci_trdy_wait <= 1'h0;
        print_verdict;
    end
endmodule
